// ### logic/dc_capture_input_1_capture.sv
// Capture input 1 edge timestamps and buffer manager event timestamps
`timescale 1ns/1ps
`default_nettype none
module dc_capture_input_1_capture import dc_capture_pkg::*; (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Capture pin and time bases
   input wire logic capture_input_1_i,
   input wire logic [63:0] system_time_i,
   input wire logic [31:0] local_time_i,
   // Acknowledge configuration
   input wire logic ack_owner_select_i,
   input wire logic host_write_ack_en_i,
   // Buffer manager events
   input wire logic frame_start_i,
   input wire logic frame_end_i,
   input wire logic buffer_manager_net_event_i,
   input wire logic buffer_manager_host_start_i,
   input wire logic buffer_manager_host_change_i,
   // Network side byte port
   input wire logic net_rd_i,
   input wire logic net_wr_i,
   input wire logic [15:0] net_addr_i,
   input wire logic [7:0] net_wdata_i,
   output logic [7:0] net_rdata_o,
   // Local host port byte port
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   input wire logic [15:0] host_addr_i,
   input wire logic [7:0] host_wdata_i,
   output logic [7:0] host_rdata_o
);

   logic [2:0] pin_sync_q;
   logic pin_q;
   logic [1:0] ctrl_q;
   logic rise_flag_q;
   logic fall_flag_q;
   logic [63:0] rise_time_q;
   logic [63:0] fall_time_q;
   logic [31:0] frame_start_time_q;
   logic frame_evt_q;
   logic [31:0] net_chg_time_q;
   logic [31:0] host_start_time_q;
   logic [31:0] host_chg_time_q;
   logic rise_edge;
   logic fall_edge;
   logic rise_cap;
   logic fall_cap;
   logic rise_ack;
   logic fall_ack;
   logic host_ack_rd;
   logic host_ack_wr;
   sel_type net_sel;
   sel_type host_sel;
   logic [2:0] stat;

   // Pin synchroniser; a change counts once stages two and three agree
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pin_sync_q <= 3'h0;
         pin_q <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], capture_input_1_i};
         if (pin_sync_q[1] == pin_sync_q[2]) pin_q <= pin_sync_q[2];
      end
   end

   // Edge detection and capture enables
   always_comb begin
      net_sel = reg_decode(net_addr_i);
      host_sel = reg_decode(host_addr_i);
      rise_edge = (pin_sync_q[1] == pin_sync_q[2]) && pin_sync_q[2] && !pin_q;
      fall_edge = (pin_sync_q[1] == pin_sync_q[2]) && !pin_sync_q[2] && pin_q;
      rise_cap = rise_edge && !(ctrl_q[CTRL_RISE_SINGLE_BIT] && rise_flag_q);
      fall_cap = fall_edge && !(ctrl_q[CTRL_FALL_SINGLE_BIT] && fall_flag_q);
   end

   // Acknowledge sources; write data plays no part in an acknowledge
   always_comb begin
      host_ack_rd = ack_owner_select_i && !host_write_ack_en_i && host_rd_i;
      host_ack_wr = ack_owner_select_i && host_write_ack_en_i && host_wr_i;
      rise_ack = (!ack_owner_select_i && net_rd_i && net_addr_i == OFS_RISE)
         || ((host_ack_rd || host_ack_wr) && host_addr_i == OFS_RISE);
      fall_ack = (!ack_owner_select_i && net_rd_i && net_addr_i == OFS_FALL)
         || ((host_ack_rd || host_ack_wr) && host_addr_i == OFS_FALL);
   end

   // Control register, written by whichever side owns the latch unit
   always_ff @(posedge mclk_i) begin
      if (rst_i) ctrl_q <= CTRL_RESET;
      else if (!ack_owner_select_i && net_wr_i && net_sel == SEL_CTRL)
         ctrl_q <= net_wdata_i[1:0];
      else if (ack_owner_select_i && host_wr_i && host_sel == SEL_CTRL)
         ctrl_q <= host_wdata_i[1:0];
   end

   // Edge timestamps; no write path exists from either port
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rise_time_q <= TIME64_RESET;
         fall_time_q <= TIME64_RESET;
      end else begin
         if (rise_cap) rise_time_q <= system_time_i;
         if (fall_cap) fall_time_q <= system_time_i;
      end
   end

   // Single-event flags; a new event wins over a same-cycle acknowledge
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rise_flag_q <= 1'b0;
         fall_flag_q <= 1'b0;
      end else begin
         if (!ctrl_q[CTRL_RISE_SINGLE_BIT]) rise_flag_q <= 1'b0;
         else if (rise_edge) rise_flag_q <= 1'b1;
         else if (rise_ack) rise_flag_q <= 1'b0;
         if (!ctrl_q[CTRL_FALL_SINGLE_BIT]) fall_flag_q <= 1'b0;
         else if (fall_edge) fall_flag_q <= 1'b1;
         else if (fall_ack) fall_flag_q <= 1'b0;
      end
   end

   // Network frame event time: stamp at frame start, kept if the frame raised an event
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         frame_start_time_q <= TIME32_RESET;
         frame_evt_q <= 1'b0;
         net_chg_time_q <= TIME32_RESET;
      end else begin
         if (frame_start_i) frame_start_time_q <= local_time_i;
         if (frame_start_i || frame_end_i) frame_evt_q <= 1'b0;
         else if (buffer_manager_net_event_i) frame_evt_q <= 1'b1;
         if (frame_end_i && (frame_evt_q || buffer_manager_net_event_i))
            net_chg_time_q <= frame_start_time_q;
      end
   end

   // Host side buffer event times
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         host_start_time_q <= TIME32_RESET;
         host_chg_time_q <= TIME32_RESET;
      end else begin
         if (buffer_manager_host_start_i) host_start_time_q <= local_time_i;
         if (buffer_manager_host_change_i) host_chg_time_q <= local_time_i;
      end
   end

   // Status byte view
   assign stat = {pin_q, fall_flag_q, rise_flag_q};

   // Network side read port
   side_snapshot #(.HOST_VIEW(1'b0)) u_net_port (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .rd_i(net_rd_i),
      .addr_i(net_addr_i),
      .ctrl_i(ctrl_q),
      .stat_i(stat),
      .rise_i(rise_time_q),
      .fall_i(fall_time_q),
      .net_chg_i(net_chg_time_q),
      .host_start_i(host_start_time_q),
      .host_chg_i(host_chg_time_q),
      .rdata_o(net_rdata_o)
   );

   // Local host port read port
   side_snapshot #(.HOST_VIEW(1'b1)) u_host_port (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .rd_i(host_rd_i),
      .addr_i(host_addr_i),
      .ctrl_i(ctrl_q),
      .stat_i(stat),
      .rise_i(rise_time_q),
      .fall_i(fall_time_q),
      .net_chg_i(net_chg_time_q),
      .host_start_i(host_start_time_q),
      .host_chg_i(host_chg_time_q),
      .rdata_o(host_rdata_o)
   );

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   // Checks of capture and acknowledge behaviour
   a_rise_capture: assert property (rise_cap |=> rise_time_q == $past(system_time_i))
      else $error("rise stamp not taken");
   a_fall_capture: assert property (fall_cap |=> fall_time_q == $past(system_time_i))
      else $error("fall stamp not taken");
   a_stamp_hold: assert property (!rise_cap && !fall_cap |=> $stable(rise_time_q) && $stable(fall_time_q))
      else $error("edge stamp changed without an edge");
   a_net_rise_ack: assert property (rise_flag_q && !ack_owner_select_i && net_rd_i
      && net_addr_i == OFS_RISE && !rise_edge |=> !rise_flag_q)
      else $error("network read did not clear rise flag");
   a_net_fall_ack: assert property (fall_flag_q && !ack_owner_select_i && net_rd_i
      && net_addr_i == OFS_FALL && !fall_edge |=> !fall_flag_q)
      else $error("network read did not clear fall flag");
   a_host_rd_ack: assert property (rise_flag_q && ack_owner_select_i && !host_write_ack_en_i
      && host_rd_i && host_addr_i == OFS_RISE && !rise_edge |=> !rise_flag_q)
      else $error("host read did not clear rise flag");
   a_host_wr_ack: assert property (fall_flag_q && ack_owner_select_i && host_write_ack_en_i
      && host_wr_i && host_addr_i == OFS_FALL && !fall_edge |=> !fall_flag_q)
      else $error("host write did not clear fall flag");
   a_rd_no_ack_wr_mode: assert property (rise_flag_q && ack_owner_select_i && host_write_ack_en_i
      && !net_rd_i && !host_wr_i && !rise_edge && ctrl_q[0] |=> rise_flag_q)
      else $error("rise flag cleared without acknowledge");
   a_single_first: assert property (rise_flag_q && ctrl_q[0] ##1 ctrl_q[0] |-> $stable(rise_time_q))
      else $error("single mode overwrote first stamp");
   a_cont_flag_zero: assert property (!ctrl_q[1] |=> !fall_flag_q)
      else $error("flag set in continuous mode");
   a_host_start: assert property (buffer_manager_host_start_i |=> host_start_time_q == $past(local_time_i))
      else $error("host start time not taken");
   a_net_frame: assert property (frame_start_i ##1 (!frame_start_i && !frame_end_i
      && buffer_manager_net_event_i) ##1 frame_end_i
      |=> net_chg_time_q == $past(local_time_i, 3))
      else $error("frame start time not kept");

endmodule : dc_capture_input_1_capture
`default_nettype wire

// ### inc/dc_capture_pkg.sv
// Constants, register map and address decode shared by the capture block
package dc_capture_pkg;

   // Register byte addresses
   localparam logic [15:0] OFS_CTRL = 16'h09a9;
   localparam logic [15:0] OFS_STAT = 16'h09af;
   localparam logic [15:0] OFS_RISE = 16'h09c0;
   localparam logic [15:0] OFS_FALL = 16'h09c8;
   localparam logic [15:0] OFS_NET_CHG = 16'h09f0;
   localparam logic [15:0] OFS_HOST_START = 16'h09f8;
   localparam logic [15:0] OFS_HOST_CHG = 16'h09fc;

   // Field positions
   localparam int CTRL_RISE_SINGLE_BIT = 0;
   localparam int CTRL_FALL_SINGLE_BIT = 1;
   localparam int STAT_RISE_EVT_BIT = 0;
   localparam int STAT_FALL_EVT_BIT = 1;
   localparam int STAT_PIN_BIT = 2;

   // Reset values
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [63:0] TIME64_RESET = 64'h0;
   localparam logic [31:0] TIME32_RESET = 32'h0;

   // Register selected by a byte address
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_CTRL = 3'b001,
      SEL_STAT = 3'b010,
      SEL_RISE = 3'b011,
      SEL_FALL = 3'b100,
      SEL_NET_CHG = 3'b101,
      SEL_HOST_START = 3'b110,
      SEL_HOST_CHG = 3'b111
   } sel_type;

   // Map a byte address onto the register that holds it
   function automatic sel_type reg_decode(input logic [15:0] a);
      sel_type s;
      s = SEL_NONE;
      if (a == OFS_CTRL) s = SEL_CTRL;
      else if (a == OFS_STAT) s = SEL_STAT;
      else if (a[15:3] == OFS_RISE[15:3]) s = SEL_RISE;
      else if (a[15:3] == OFS_FALL[15:3]) s = SEL_FALL;
      else if (a[15:2] == OFS_NET_CHG[15:2]) s = SEL_NET_CHG;
      else if (a[15:2] == OFS_HOST_START[15:2]) s = SEL_HOST_START;
      else if (a[15:2] == OFS_HOST_CHG[15:2]) s = SEL_HOST_CHG;
      return s;
   endfunction : reg_decode

endpackage : dc_capture_pkg

// ### logic/side_snapshot.sv
// Per-side read port: upper-bit snapshots and registered byte read data
`timescale 1ns/1ps
`default_nettype none
module side_snapshot import dc_capture_pkg::*; #(
   parameter bit HOST_VIEW = 1'b0
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Byte read request from this side
   input wire logic rd_i,
   input wire logic [15:0] addr_i,
   // Live register contents
   input wire logic [1:0] ctrl_i,
   input wire logic [2:0] stat_i,
   input wire logic [63:0] rise_i,
   input wire logic [63:0] fall_i,
   input wire logic [31:0] net_chg_i,
   input wire logic [31:0] host_start_i,
   input wire logic [31:0] host_chg_i,
   // Read data, valid the cycle after rd_i
   output logic [7:0] rdata_o
);

   sel_type sel;
   logic [2:0] idx;
   logic low_byte;
   logic [55:0] snap_rise_q;
   logic [55:0] snap_fall_q;
   logic [23:0] snap_net_q;
   logic [23:0] snap_hstart_q;
   logic [23:0] snap_hchg_q;
   logic [63:0] word;
   logic [7:0] rdata_d;

   // Address decode and byte position; control and status are single bytes at index 0
   always_comb begin
      sel = reg_decode(addr_i);
      idx = 3'h0;
      if (sel == SEL_RISE || sel == SEL_FALL) idx = addr_i[2:0];
      else if (sel == SEL_NET_CHG || sel == SEL_HOST_START || sel == SEL_HOST_CHG)
         idx = {1'b0, addr_i[1:0]};
      low_byte = (idx == 3'h0);
   end

   // Freeze the upper bits when the low byte is read, one set per side
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         snap_rise_q <= 56'h0;
         snap_fall_q <= 56'h0;
         snap_net_q <= 24'h0;
         snap_hstart_q <= 24'h0;
         snap_hchg_q <= 24'h0;
      end else if (rd_i && low_byte) begin
         unique case (sel)
            SEL_RISE: snap_rise_q <= rise_i[63:8];
            SEL_FALL: snap_fall_q <= fall_i[63:8];
            SEL_NET_CHG: snap_net_q <= net_chg_i[31:8];
            SEL_HOST_START: snap_hstart_q <= host_start_i[31:8];
            SEL_HOST_CHG: snap_hchg_q <= host_chg_i[31:8];
            SEL_NONE, SEL_CTRL, SEL_STAT: ;
         endcase
      end
   end

   // Low byte comes live, upper bytes from the snapshot; host event times read zero on the network side
   always_comb begin
      word = 64'h0;
      unique case (sel)
         SEL_CTRL: word = {62'h0, ctrl_i};
         SEL_STAT: word = {61'h0, stat_i};
         SEL_RISE: word = {snap_rise_q, rise_i[7:0]};
         SEL_FALL: word = {snap_fall_q, fall_i[7:0]};
         SEL_NET_CHG: word = {32'h0, snap_net_q, net_chg_i[7:0]};
         SEL_HOST_START: word = HOST_VIEW ? {32'h0, snap_hstart_q, host_start_i[7:0]} : 64'h0;
         SEL_HOST_CHG: word = HOST_VIEW ? {32'h0, snap_hchg_q, host_chg_i[7:0]} : 64'h0;
         SEL_NONE: word = 64'h0;
      endcase
      rdata_d = word[{idx, 3'b000} +: 8];
   end

   // Registered read data, zero when no read
   always_ff @(posedge mclk_i) begin
      if (rst_i) rdata_o <= 8'h00;
      else rdata_o <= rd_i ? rdata_d : 8'h00;
   end

endmodule : side_snapshot
`default_nettype wire

// ### bench/time_source.sv
// Behavioural time bases and frame traffic standing in for the network side
`timescale 1ns/1ps
`default_nettype none
module time_source (
   // Clock
   input wire logic mclk_i,
   // Time bases
   output logic [63:0] system_time_o,
   output logic [31:0] local_time_o,
   // Frame traffic
   output logic frame_start_o,
   output logic frame_end_o,
   output logic evt_o
);
   // Quiet lines from time zero
   initial begin
      system_time_o = 64'h0;
      local_time_o = 32'h0;
      frame_start_o = 1'b0;
      frame_end_o = 1'b0;
      evt_o = 1'b0;
   end

   // Times are held still so a stamp has one right value
   task automatic set_time(input logic [63:0] s, input logic [31:0] l);
      @(posedge mclk_i);
      system_time_o <= s;
      local_time_o <= l;
   endtask : set_time

   // One frame; local time moves after the start so a late capture shows
   task automatic frame(input logic [31:0] l, input bit e);
      set_time(system_time_o, l);
      frame_start_o <= 1'b1;
      @(posedge mclk_i);
      frame_start_o <= 1'b0;
      local_time_o <= ~l;
      evt_o <= e;
      @(posedge mclk_i);
      evt_o <= 1'b0;
      frame_end_o <= 1'b1;
      @(posedge mclk_i);
      frame_end_o <= 1'b0;
   endtask : frame
endmodule : time_source
`default_nettype wire

// ### bench/dc_capture_input_1_capture_tb.sv
// Self-checking bench for the capture block
`timescale 1ns/1ps
`default_nettype none
module dc_capture_input_1_capture_tb import dc_capture_pkg::*;;
   logic mclk_i, rst_i, pin, own, wack, hs, hc, nrd, nwr, hrd, hwr;
   logic [15:0] nad, had;
   logic [7:0] nwd, hwd, nq, hq, q;
   logic [63:0] st, v;
   logic [31:0] lt;
   logic fs, fe, ev;
   int error_cnt = 0;
   int n_compared = 0;

   time_source time_source_i (.mclk_i(mclk_i), .system_time_o(st), .local_time_o(lt),
      .frame_start_o(fs), .frame_end_o(fe), .evt_o(ev));
   dc_capture_input_1_capture dc_capture_input_1_capture_i (.mclk_i(mclk_i), .rst_i(rst_i),
      .capture_input_1_i(pin), .system_time_i(st), .local_time_i(lt),
      .ack_owner_select_i(own), .host_write_ack_en_i(wack), .frame_start_i(fs),
      .frame_end_i(fe), .buffer_manager_net_event_i(ev), .buffer_manager_host_start_i(hs),
      .buffer_manager_host_change_i(hc), .net_rd_i(nrd), .net_wr_i(nwr), .net_addr_i(nad),
      .net_wdata_i(nwd), .net_rdata_o(nq), .host_rd_i(hrd), .host_wr_i(hwr),
      .host_addr_i(had), .host_wdata_i(hwd), .host_rdata_o(hq));

   // 100 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // One byte access from one side; read data lands in q
   task automatic acc(input bit h, input bit w, input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      nrd <= !h && !w;
      nwr <= !h && w;
      hrd <= h && !w;
      hwr <= h && w;
      nad <= a;
      had <= a;
      nwd <= d;
      hwd <= d;
      @(posedge mclk_i);
      nrd <= 1'b0;
      nwr <= 1'b0;
      hrd <= 1'b0;
      hwr <= 1'b0;
      #1 q = h ? hq : nq;
   endtask : acc

   // Bytes s to n-1 of a stamp, low byte first, into v
   task automatic rdn(input bit h, input logic [15:0] a, input int n, input int s);
      for (int i = s; i < n; i++) begin
         acc(h, 1'b0, a + 16'(i), 8'h00);
         v[i*8 +: 8] = q;
      end
   endtask : rdn

   task automatic stat(input logic [1:0] e);
      acc(1'b0, 1'b0, OFS_STAT, 8'h00);
      chk(64'(q), 64'({5'h0, pin, e}));
   endtask : stat

   // Pin change with system time held, then time for the filter
   task automatic edg(input logic lv, input logic [63:0] t);
      time_source_i.set_time(t, lt);
      pin <= lv;
      repeat (8) @(posedge mclk_i);
   endtask : edg

   task automatic hev(input bit c, input logic [31:0] l);
      time_source_i.set_time(st, l);
      hs <= !c;
      hc <= c;
      @(posedge mclk_i);
      hs <= 1'b0;
      hc <= 1'b0;
      time_source_i.set_time(st, ~l);
   endtask : hev

   task automatic t_cont();
      rdn(1'b0, OFS_RISE, 8, 0);
      chk(v, 64'h0);
      edg(1'b1, 64'h1122334455667788);
      edg(1'b0, 64'h0a0b0c0d0e0f1011);
      rdn(1'b0, OFS_RISE, 8, 0);
      chk(v, 64'h1122334455667788);
      rdn(1'b1, OFS_FALL, 8, 0);
      chk(v, 64'h0a0b0c0d0e0f1011);
      stat(2'h0);
   endtask : t_cont

   task automatic t_snap();
      rdn(1'b0, OFS_RISE, 1, 0);
      edg(1'b1, 64'hffeeddccbbaa9988);
      rdn(1'b0, OFS_RISE, 8, 1);
      chk(v, 64'h1122334455667788);
      rdn(1'b1, OFS_RISE, 8, 0);
      chk(v, 64'hffeeddccbbaa9988);
      acc(1'b0, 1'b1, OFS_RISE, 8'hff);
      acc(1'b0, 1'b1, OFS_FALL, 8'hff);
      rdn(1'b1, OFS_RISE, 8, 0);
      chk(v, 64'hffeeddccbbaa9988);
      edg(1'b0, 64'h5);
   endtask : t_snap

   task automatic t_single();
      acc(1'b0, 1'b1, OFS_CTRL, 8'h03);
      edg(1'b1, 64'ha1);
      edg(1'b0, 64'hb2);
      stat(2'h3);
      edg(1'b1, 64'hc3);
      stat(2'h3);
      edg(1'b0, 64'hd4);
      rdn(1'b0, OFS_RISE, 8, 0);
      chk(v, 64'ha1);
      stat(2'h2);
      rdn(1'b0, OFS_FALL, 8, 0);
      chk(v, 64'hb2);
      stat(2'h0);
   endtask : t_single

   task automatic t_host();
      @(posedge mclk_i);
      own <= 1'b1;
      edg(1'b1, 64'he5);
      edg(1'b0, 64'hf6);
      acc(1'b1, 1'b1, OFS_RISE, 8'h00);
      stat(2'h3);
      rdn(1'b1, OFS_RISE, 1, 0);
      stat(2'h2);
      rdn(1'b0, OFS_FALL, 1, 0);
      stat(2'h2);
      rdn(1'b1, OFS_FALL, 1, 0);
      stat(2'h0);
      @(posedge mclk_i);
      wack <= 1'b1;
      edg(1'b1, 64'h17);
      edg(1'b0, 64'h28);
      rdn(1'b1, OFS_RISE, 1, 0);
      stat(2'h3);
      acc(1'b1, 1'b1, OFS_RISE, 8'h00);
      stat(2'h2);
      rdn(1'b1, OFS_RISE, 8, 0);
      chk(v, 64'h17);
      acc(1'b1, 1'b1, OFS_FALL, 8'h00);
      stat(2'h0);
   endtask : t_host

   task automatic t_events();
      time_source_i.frame(32'h13572468, 1'b1);
      time_source_i.frame(32'h99999999, 1'b0);
      rdn(1'b0, OFS_NET_CHG, 1, 0);
      time_source_i.frame(32'h2468ace0, 1'b1);
      rdn(1'b0, OFS_NET_CHG, 4, 1);
      chk(64'(v[31:0]), 64'h13572468);
      rdn(1'b1, OFS_NET_CHG, 4, 0);
      chk(64'(v[31:0]), 64'h2468ace0);
      hev(1'b0, 32'habcd0123);
      hev(1'b1, 32'h0badf00d);
      rdn(1'b1, OFS_HOST_START, 4, 0);
      chk(64'(v[31:0]), 64'habcd0123);
      rdn(1'b1, OFS_HOST_CHG, 4, 0);
      chk(64'(v[31:0]), 64'h0badf00d);
   endtask : t_events

   // Non-owner control write refused, then a mid-run reset clears everything
   task automatic t_reset();
      acc(1'b0, 1'b1, OFS_CTRL, 8'h00);
      acc(1'b0, 1'b0, OFS_CTRL, 8'h00);
      chk(64'(q), 64'h3);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      rdn(1'b1, OFS_NET_CHG, 4, 1);
      chk(64'(v[31:8]), 64'h0);
      rdn(1'b1, OFS_FALL, 8, 0);
      chk(v, 64'h0);
      rdn(1'b0, OFS_NET_CHG, 4, 0);
      chk(64'(v[31:0]), 64'h0);
      rdn(1'b1, OFS_HOST_CHG, 4, 0);
      chk(64'(v[31:0]), 64'h0);
      stat(2'h0);
      acc(1'b0, 1'b0, OFS_CTRL, 8'h00);
      chk(64'(q), 64'h0);
   endtask : t_reset

   task automatic wrap_up();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // Main sequence after a 6-cycle reset
   initial begin
      {pin, own, wack, hs, hc, nrd, nwr, hrd, hwr} = 9'h0;
      {nad, had, nwd, hwd} = 48'h0;
      rst_i = 1'b1;
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_cont();
      t_snap();
      t_single();
      t_host();
      t_events();
      t_reset();
      wrap_up();
   end

   // Watchdog well past the expected run length
   initial begin
      #100us;
      error_cnt++;
      wrap_up();
   end
endmodule : dc_capture_input_1_capture_tb
`default_nettype wire
